/* bench/oms_rom_model.sv */
// Behavioural on-chip ROM array answering program-space data reads
`timescale 1ns/1ps
module oms_rom_model (
    input  wire logic              clk_i,      // Core clock
    input  wire oms_pkg::oms_acc_s pr_i,       // Program-space read
    output logic [15:0]            rom_data_o  // ROM word, same cycle
);
    logic tog_q = 1'b0;
    // Idle bus shows a pattern that flips each cycle
    always_ff @(posedge clk_i) begin
        tog_q <= ~tog_q;
    end
    assign rom_data_o = pr_i.vld ? (pr_i.addr[15:0] ^ 16'h3c3c)
                                 : (16'ha5a5 ^ {16{tog_q}});
endmodule

/* bench/oms_top_tb.sv */
// Self-checking bench for the memory map and security block
`timescale 1ns/1ps
`include "oms_cfg.svh"
module oms_top_tb;
    logic                   clk_i;
    logic                   rst_i;
    logic                   mode_pin_i;
    logic [1:0]             sec_opt_i;
    logic [`OMS_REG_AW-1:0] reg_addr_i;
    logic [15:0]            reg_wdata_i;
    logic                   reg_wr_i;
    logic                   reg_rd_i;
    logic [15:0]            reg_rdata_o;
    oms_pkg::oms_acc_s      pf_i, pr_i, da_i, db_i, dw_i;
    oms_pkg::oms_sel_s      pf_sel_o, pr_sel_o, da_sel_o, db_sel_o, dw_sel_o;
    logic [15:0]            rom_data_i, prot_data_o, hp_addr_i, vec_addr_o;
    logic                   conflict_o, rom_lock_o, hp_rd_i, hp_wr_i;
    logic                   hp_rd_ok_o, hp_wr_ok_o, emu_en_o, bscan_en_o;
    logic                   vec_req_i, vec_valid_o;
    logic [4:0]             vec_slot_i;
    logic [15:0]            v;
    int                     fail_count, tests_run;
    int                     cycles = 0;

    oms_top uut (.clk_i(clk_i), .rst_i(rst_i), .mode_pin_i(mode_pin_i),
        .sec_opt_i(sec_opt_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pf_i(pf_i), .pr_i(pr_i), .da_i(da_i),
        .db_i(db_i), .dw_i(dw_i), .rom_data_i(rom_data_i),
        .prot_data_o(prot_data_o), .pf_sel_o(pf_sel_o), .pr_sel_o(pr_sel_o),
        .da_sel_o(da_sel_o), .db_sel_o(db_sel_o), .dw_sel_o(dw_sel_o),
        .conflict_o(conflict_o), .rom_lock_o(rom_lock_o), .hp_rd_i(hp_rd_i),
        .hp_wr_i(hp_wr_i), .hp_addr_i(hp_addr_i), .hp_rd_ok_o(hp_rd_ok_o),
        .hp_wr_ok_o(hp_wr_ok_o), .emu_en_o(emu_en_o),
        .bscan_en_o(bscan_en_o), .vec_req_i(vec_req_i),
        .vec_slot_i(vec_slot_i), .vec_valid_o(vec_valid_o),
        .vec_addr_o(vec_addr_o));
    oms_rom_model u_rom (.clk_i(clk_i), .pr_i(pr_i), .rom_data_o(rom_data_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Ends the request cycle, lets the answer land
    task automatic step();
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i, hp_rd_i, hp_wr_i, vec_req_i} <= 5'h00;
        {pf_i.vld, pr_i.vld, da_i.vld, db_i.vld, dw_i.vld} <= 5'h00;
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        step();
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        step();
        v = reg_rdata_o;
    endtask

    task automatic acc2(input logic [22:0] f, input logic [22:0] r);
        @(posedge clk_i);
        pf_i <= '{1'b1, f};
        pr_i <= '{1'b1, r};
        step();
    endtask

    task automatic do_reset(input logic [1:0] s, input logic p,
                            input logic [15:0] m, input logic e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        sec_opt_i <= s;
        mode_pin_i <= p;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        mode_pin_i <= ~p;
        @(posedge clk_i);
        #1;
        chk(16'(vec_valid_o), 16'h1);
        chk(vec_addr_o, 16'hff80);
        chk(16'(bscan_en_o), 16'h1);
        step();
        chk(16'(vec_valid_o), 16'h0);
        chk(16'(emu_en_o), 16'(e));
        rd(`OMS_OFS_MODE);
        chk(v, m);
    endtask

    task automatic t_regs();
        wr(`OMS_OFS_STAT, 16'hffff);
        rd(`OMS_OFS_STAT);
        chk(v, 16'h0008);
        rd(4'h7);
        chk(v, 16'h0000);
        wr(`OMS_OFS_MODE, 16'h52e8);
        rd(`OMS_OFS_MODE);
        chk(v, 16'h52e8);
        step();
        chk(reg_rdata_o, 16'h0000);
    endtask

    task automatic t_host(input logic lim);
        logic [15:0] tb[4];
        tb = '{16'h3fff, 16'h4000, 16'h5fff, 16'h6000};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            hp_addr_i <= tb[i];
            hp_rd_i <= 1'b1;
            hp_wr_i <= 1'b1;
            step();
            chk(16'(hp_rd_ok_o), 16'(!lim || i == 1 || i == 2));
            chk(16'(hp_wr_ok_o), 16'h1);
        end
    endtask

    task automatic t_data();
        logic e;
        for (int d = 0; d < 2; d++) begin
            wr(`OMS_OFS_MODE, d == 1 ? 16'hff88 : 16'hff80);
            for (int n = 0; n < 8; n++) begin
                e = (n < 4) || (d == 1);
                @(posedge clk_i);
                da_i <= '{1'b1, n == 0 ? 23'h80 : 23'(n << 13)};
                db_i <= '{1'b1, 23'(n << 13) | 23'h1fff};
                step();
                chk(16'({da_sel_o.dual, da_sel_o.single}), 16'({e, 1'b0}));
                chk(16'({db_sel_o.dual, e ? db_sel_o.idx : 3'(n)}),
                    16'({e, 3'(n)}));
                chk(16'(conflict_o), 16'h0);
            end
        end
        @(posedge clk_i);
        da_i <= '{1'b1, 23'h2000};
        db_i <= '{1'b1, 23'h2001};
        dw_i <= '{1'b1, 23'h3000};
        step();
        chk(16'(conflict_o), 16'h1);
        chk(16'(dw_sel_o), 16'h21);
        @(posedge clk_i);
        da_i <= '{1'b1, 23'h7f};
        step();
        chk(16'(da_sel_o.dual), 16'h0);
    endtask

    task automatic t_prog();
        wr(`OMS_OFS_MODE, 16'hffa0);
        for (int n = 0; n < 4; n++) begin
            acc2(23'h018000 + 23'(n << 13), 23'h028000 + 23'(n << 13));
            chk(16'(pf_sel_o), 16'({3'b100, 3'(n + 4)}));
            chk(16'(pr_sel_o), 16'({3'b010, 3'(n)}));
            chk(16'(conflict_o), 16'h0);
            acc2(23'(n << 13) | 23'h80, 23'h038000 + 23'(n << 13));
            chk(16'(pf_sel_o), 16'({3'b100, 3'(n)}));
            chk(16'(pr_sel_o), 16'({3'b010, 3'(n + 4)}));
        end
        acc2(23'h02a000, 23'h02a010);
        chk(16'(conflict_o), 16'h1);
        acc2(23'h00007f, 23'h00c000);
        chk(16'(pf_sel_o.dual), 16'h0);
        chk(16'(pr_sel_o.rom), 16'h1);
        wr(`OMS_OFS_MODE, 16'hffe0);
        acc2(23'h00c000, 23'h00c000);
        chk(16'(pf_sel_o.rom), 16'h0);
        wr(`OMS_OFS_MODE, 16'hff80);
    endtask

    task automatic t_lock();
        acc2(23'h018000, 23'h018010);
        acc2(23'h018004, 23'h00c010);
        chk(prot_data_o, 16'hffff);
        chk(16'(rom_lock_o), 16'h1);
        acc2(23'h00ff80, 23'h018010);
        acc2(23'h00ff84, 23'h00c010);
        chk(prot_data_o, 16'hc010 ^ 16'h3c3c);
        chk(16'(rom_lock_o), 16'h0);
        rd(`OMS_OFS_STAT);
        chk(v, 16'h0006);
        acc2(23'h018000, 23'h01a010);
        chk(16'(rom_lock_o), 16'h0);
        chk(16'(pr_sel_o), 16'h25);
    endtask

    task automatic t_vec();
        wr(`OMS_OFS_MODE, 16'h5280);
        for (int s = 0; s < 32; s += 31) begin
            @(posedge clk_i);
            vec_req_i <= 1'b1;
            vec_slot_i <= 5'(s);
            step();
            chk(16'(vec_valid_o), 16'h1);
            chk(vec_addr_o, 16'h5280 | 16'(s << 2));
            step();
            chk(16'(vec_valid_o), 16'h0);
        end
    endtask

    initial begin
        {rst_i, mode_pin_i, reg_wr_i, reg_rd_i} = 4'h8;
        {hp_rd_i, hp_wr_i, vec_req_i} = 3'h0;
        sec_opt_i = 2'h0;
        reg_addr_i = '0;
        reg_wdata_i = 16'h0000;
        hp_addr_i = 16'h0000;
        vec_slot_i = 5'h00;
        {pf_i, pr_i, da_i, db_i, dw_i} = '0;
        fail_count = 0;
        tests_run = 0;
        do_reset(2'b00, 1'b1, 16'hffc0, 1'b1);
        t_regs();
        do_reset(2'b01, 1'b1, 16'hffc0, 1'b0);
        t_host(1'b0);
        do_reset(2'b10, 1'b1, 16'hff80, 1'b0);
        t_host(1'b1);
        t_prog();
        t_lock();
        t_data();
        do_reset(2'b11, 1'b1, 16'hff80, 1'b0);
        t_host(1'b1);
        t_vec();
        end_of_test();
    end
endmodule

/* hw/oms_top.sv */
// On-chip memory decode, security gating and vector relocation
`timescale 1ns/1ps
`include "oms_cfg.svh"
module oms_top (
    input  wire logic                 clk_i,       // Core clock 20 MHz
    input  wire logic                 rst_i,       // Hardware reset, high
    input  wire logic                 mode_pin_i,  // External ROM mode pin
    input  wire logic [1:0]           sec_opt_i,   // Mask security strap
    input  wire logic [`OMS_REG_AW-1:0] reg_addr_i, // Register address
    input  wire logic [15:0]          reg_wdata_i, // Register write data
    input  wire logic                 reg_wr_i,    // Register write strobe
    input  wire logic                 reg_rd_i,    // Register read strobe
    output logic [15:0]               reg_rdata_o, // Read data, next cycle
    input  wire oms_pkg::oms_acc_s    pf_i,        // Program fetch
    input  wire oms_pkg::oms_acc_s    pr_i,        // Program-space data read
    input  wire oms_pkg::oms_acc_s    da_i,        // Data read A
    input  wire oms_pkg::oms_acc_s    db_i,        // Data read B
    input  wire oms_pkg::oms_acc_s    dw_i,        // Data write
    input  wire logic [15:0]          rom_data_i,  // ROM word for pr read
    output logic [15:0]               prot_data_o, // pr data after lock
    output oms_pkg::oms_sel_s         pf_sel_o,    // Fetch select
    output oms_pkg::oms_sel_s         pr_sel_o,    // Program read select
    output oms_pkg::oms_sel_s         da_sel_o,    // Data read A select
    output oms_pkg::oms_sel_s         db_sel_o,    // Data read B select
    output oms_pkg::oms_sel_s         dw_sel_o,    // Data write select
    output logic                      conflict_o,  // Block over-subscribed
    output logic                      rom_lock_o,  // ROM read was masked
    input  wire logic                 hp_rd_i,     // Host-port read
    input  wire logic                 hp_wr_i,     // Host-port write
    input  wire logic [15:0]          hp_addr_i,   // Host-port address
    output logic                      hp_rd_ok_o,  // Host read honoured
    output logic                      hp_wr_ok_o,  // Host write honoured
    output logic                      emu_en_o,    // Scan emulation allowed
    output logic                      bscan_en_o,  // Boundary scan allowed
    input  wire logic                 vec_req_i,   // Interrupt or trap taken
    input  wire logic [4:0]           vec_slot_i,  // Vector slot number
    output logic                      vec_valid_o, // Load PC now
    output logic [15:0]               vec_addr_o   // Vector fetch address
);
    // Pin synchronisers
    logic             mode_s1_q;
    logic             mode_s2_q;
    logic [1:0]       sec_s1_q;
    logic [1:0]       sec_s2_q;
    oms_pkg::oms_sec_e sec_q;
    // Mode register fields
    logic [8:0]       vpp_q;
    logic             romdis_q;
    logic             overlay_bit_q;
    logic             dmap_q;
    logic             exec_rom_q;
    logic             boot_q;
    logic             sec_on;
    logic             sec_rr;
    logic [15:0]      mode_word;
    oms_pkg::oms_sel_s pf_d;
    oms_pkg::oms_sel_s pr_d;
    oms_pkg::oms_sel_s da_d;
    oms_pkg::oms_sel_s db_d;
    oms_pkg::oms_sel_s dw_d;
    logic             conflict_d;
    logic             lock_d;
    logic             hp_in_win;

    // Data-space decode
    function automatic oms_pkg::oms_sel_s dsel(
        input logic        vld,
        input logic [15:0] a,
        input logic        dmap
    );
        oms_pkg::oms_sel_s s;
        s        = '0;
        s.idx    = a[15:13];                                   // R6
        s.dual   = vld && (a[15:7] != 9'h000)                  // R21
                   && (!a[15] || dmap);                         // R2 R3 R22
        return s;
    endfunction

    // Program-space decode
    function automatic oms_pkg::oms_sel_s psel(
        input logic        vld,
        input logic [22:0] a,
        input logic        overlay_bit,
        input logic        romdis
    );
        oms_pkg::oms_sel_s s;
        logic [6:0]        pg;
        s  = '0;
        pg = a[22:16];
        if (vld) begin
            unique case (pg)
                `OMS_PG_LOW: begin
                    s.rom  = (a[15:14] == 2'b11) && !romdis;   // R19
                    s.dual = overlay_bit && !a[15]
                             && (a[15:7] != 9'h000);           // R2 R21
                    s.idx  = {1'b0, a[14:13]};
                end
                `OMS_PG_DUAL: begin
                    s.dual = a[15];                            // R3 R7
                    s.idx  = {1'b1, a[14:13]};
                end
                `OMS_PG_SGL_A, `OMS_PG_SGL_B: begin
                    s.single = a[15];                          // R5 R8
                    s.idx    = {a[16], a[14:13]};
                end
                default: begin
                    s = '0;
                end
            endcase
        end
        return s;
    endfunction

    assign sec_on = (sec_q != oms_pkg::OMS_SEC_NONE);
    assign sec_rr = (sec_q == oms_pkg::OMS_SEC_RAM_ROM) ||
                    (sec_q == oms_pkg::OMS_SEC_RSVD);
    assign mode_word = {vpp_q, romdis_q, overlay_bit_q, 1'b0, dmap_q, 3'b000};

    always_ff @(posedge clk_i) begin
        mode_s1_q <= mode_pin_i;
        mode_s2_q <= mode_s1_q;
        sec_s1_q  <= sec_opt_i;
        sec_s2_q  <= sec_s1_q;
    end

    // Strap is held during reset; captured there
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sec_q <= oms_pkg::oms_sec_e'(sec_s2_q);
        end
    end

    // Vector page pointer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vpp_q <= `OMS_VPP_RST;                             // R17 R18
        end else if (reg_wr_i && reg_addr_i == `OMS_OFS_MODE) begin
            vpp_q <= reg_wdata_i[`OMS_VPP_HI:`OMS_VPP_LO];     // R16
        end
    end

    // ROM mode bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            romdis_q <= sec_rr ? 1'b0 : mode_s2_q;             // R12 R14 R20
        end else if (reg_wr_i && reg_addr_i == `OMS_OFS_MODE) begin
            romdis_q <= reg_wdata_i[`OMS_BIT_ROMDIS];          // R12 R20
        end
    end

    // Overlay and data-map bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overlay_bit_q <= `OMS_OVERLAY_BIT_RST;                           // R21
            dmap_q <= `OMS_DMAP_RST;                           // R22
        end else if (reg_wr_i && reg_addr_i == `OMS_OFS_MODE) begin
            overlay_bit_q <= reg_wdata_i[`OMS_BIT_OVERLAY_BIT];
            dmap_q <= reg_wdata_i[`OMS_BIT_DMAP];
        end
    end

    // Register read port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `OMS_OFS_MODE: reg_rdata_o <= mode_word;
                `OMS_OFS_STAT: reg_rdata_o <= {12'h000, emu_en_o,
                                               exec_rom_q, sec_q};
                default:       reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // Combinational decode of all buses
    always_comb begin
        pf_d = psel(pf_i.vld, pf_i.addr, overlay_bit_q, romdis_q);
        pr_d = psel(pr_i.vld, pr_i.addr, overlay_bit_q, romdis_q);
        da_d = dsel(da_i.vld, da_i.addr[15:0], dmap_q);
        db_d = dsel(db_i.vld, db_i.addr[15:0], dmap_q);
        dw_d = dsel(dw_i.vld, dw_i.addr[15:0], dmap_q);
    end

    // Port occupancy per block
    always_comb begin
        logic [2:0] nd;
        logic [2:0] ns;
        conflict_d = 1'b0;
        nd = 3'd0;
        ns = 3'd0;
        for (int b = 0; b < `OMS_NBLK; b++) begin
            nd = 3'd0;
            ns = 3'd0;
            nd = nd + {2'b00, pf_d.dual && pf_d.idx == 3'(b)};
            nd = nd + {2'b00, pr_d.dual && pr_d.idx == 3'(b)};
            nd = nd + {2'b00, da_d.dual && da_d.idx == 3'(b)};
            nd = nd + {2'b00, db_d.dual && db_d.idx == 3'(b)};
            nd = nd + {2'b00, dw_d.dual && dw_d.idx == 3'(b)};
            ns = ns + {2'b00, pf_d.single && pf_d.idx == 3'(b)};
            ns = ns + {2'b00, pr_d.single && pr_d.idx == 3'(b)};
            if (nd > 3'd2) begin
                conflict_d = 1'b1;                             // R1
            end
            if (ns > 3'd1) begin
                conflict_d = 1'b1;                             // R4
            end
        end
    end

    // Only ROM data reads are masked; RAM never
    assign lock_d = pr_d.rom && sec_on && !exec_rom_q;         // R9 R10

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pf_sel_o   <= '0;
            pr_sel_o   <= '0;
            da_sel_o   <= '0;
            db_sel_o   <= '0;
            dw_sel_o   <= '0;
            conflict_o <= 1'b0;
        end else begin
            pf_sel_o   <= pf_d;
            pr_sel_o   <= pr_d;
            da_sel_o   <= da_d;
            db_sel_o   <= db_d;
            dw_sel_o   <= dw_d;
            conflict_o <= conflict_d;                          // R1 R4
        end
    end

    // Origin of the executing code; branches into ROM stay legal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exec_rom_q <= 1'b0;
        end else if (pf_i.vld) begin
            exec_rom_q <= pf_d.rom;                            // R9
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_data_o <= 16'h0000;
            rom_lock_o  <= 1'b0;
        end else begin
            prot_data_o <= lock_d ? `OMS_ROM_LOCK_VAL : rom_data_i; // R9
            rom_lock_o  <= lock_d;
        end
    end

    // Host-port gating
    assign hp_in_win = (hp_addr_i >= `OMS_HP_LO) &&
                       (hp_addr_i <= `OMS_HP_HI);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hp_rd_ok_o <= 1'b0;
            hp_wr_ok_o <= 1'b0;
        end else begin
            hp_rd_ok_o <= hp_rd_i && (!sec_rr || hp_in_win);   // R13 R14
            hp_wr_ok_o <= hp_wr_i;                             // R13 R14
        end
    end

    // Emulation access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            emu_en_o   <= 1'b0;
            bscan_en_o <= 1'b1;
        end else begin
            emu_en_o   <= !sec_on;                             // R11
            bscan_en_o <= 1'b1;                                // R11
        end
    end

    // Vector generation; reset vector issued after release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_q      <= 1'b1;
            vec_valid_o <= 1'b0;
            vec_addr_o  <= {`OMS_VPP_RST, 7'h00};              // R16
        end else if (boot_q) begin
            boot_q      <= 1'b0;
            vec_valid_o <= 1'b1;                               // R15
            vec_addr_o  <= {vpp_q, 7'h00};                     // R17
        end else if (vec_req_i) begin
            vec_valid_o <= 1'b1;                               // R15
            vec_addr_o  <= {vpp_q, vec_slot_i, 2'b00};         // R23
        end else begin
            vec_valid_o <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_rom_lock_val: assert property ( // R9
        pr_i.vld && pr_d.rom && sec_on && !exec_rom_q
        |=> prot_data_o == 16'hffff && rom_lock_o)
        else $error("ROM read not masked");
    a_ram_never_lock: assert property ( // R10
        pr_i.vld && !pr_d.rom |=> !rom_lock_o)
        else $error("RAM read masked");
    a_emu_disabled: assert property ( // R11
        sec_on ##1 sec_on |-> !emu_en_o && bscan_en_o)
        else $error("Emulation open under security");
    a_emu_open: assert property ( // R11
        !sec_on ##1 !sec_on |-> emu_en_o)
        else $error("Emulation closed without security");
    a_mode_forced: assert property ( // R12
        $past(rst_i) && sec_rr |-> !romdis_q)
        else $error("ROM mode not forced");
    a_mode_pin: assert property ( // R14 R20
        $past(rst_i) && !sec_rr |-> romdis_q == $past(mode_s2_q))
        else $error("ROM mode not from pin");
    a_host_window: assert property ( // R13
        hp_rd_i && sec_rr && !hp_in_win |=> !hp_rd_ok_o)
        else $error("Host read outside window");
    a_host_write: assert property ( // R13
        hp_wr_i |=> hp_wr_ok_o)
        else $error("Host write refused");
    a_host_free: assert property ( // R14
        hp_rd_i && !sec_rr |=> hp_rd_ok_o)
        else $error("Host read refused");
    a_vpp_reset: assert property ( // R17
        $past(rst_i) |-> vpp_q == 9'h1ff ##1 vec_valid_o
        && vec_addr_o == 16'hff80)
        else $error("Reset vector wrong");
    a_vec_addr: assert property ( // R23
        !boot_q && vec_req_i |=> vec_valid_o
        && vec_addr_o == {$past(vpp_q), $past(vec_slot_i), 2'b00})
        else $error("Vector address wrong");
    a_vec_quiet: assert property ( // R15
        !boot_q && !vec_req_i |=> !vec_valid_o)
        else $error("Vector without request");
    a_page0_out: assert property ( // R21
        da_i.vld && da_i.addr[15:7] == 9'h000 |=> !da_sel_o.dual)
        else $error("Page 0 decoded");
    a_dmap_gate: assert property ( // R22
        da_i.vld && da_i.addr[15] && !dmap_q |=> !da_sel_o.dual)
        else $error("Dual 4-7 in data space");
    a_dmap_open: assert property ( // R3
        da_i.vld && da_i.addr[15] && dmap_q |=> da_sel_o.dual)
        else $error("Mapped dual block missing");
    a_overlay_bit_prog: assert property ( // R2
        pf_i.vld && overlay_bit_q && pf_i.addr[22:15] == 8'h00
        && pf_i.addr[14:7] != 8'h00 |=> pf_sel_o.dual)
        else $error("Overlay fetch not on dual block");
    a_prog_dual4: assert property ( // R7
        pf_i.vld && pf_i.addr[22:13] == 10'h00c
        |=> pf_sel_o.dual && pf_sel_o.idx == 3'h4)
        else $error("Dual block 4 fetch wrong");
    a_single_top: assert property ( // R8
        pr_i.vld && pr_i.addr[22:13] == 10'h01f
        |=> pr_sel_o.single && pr_sel_o.idx == 3'h7)
        else $error("Single block 7 read wrong");
    a_rom_hidden: assert property ( // R19
        pf_i.vld && romdis_q |=> !pf_sel_o.rom)
        else $error("ROM decoded while removed");
    a_dual_three: assert property ( // R1
        da_d.dual && db_d.dual && dw_d.dual && da_d.idx == db_d.idx
        && da_d.idx == dw_d.idx |=> conflict_o)
        else $error("Dual block over-use missed");
    a_single_share: assert property ( // R4
        pf_d.single && pr_d.single && pf_d.idx == pr_d.idx
        |=> conflict_o)
        else $error("Single block shared");

    c_vec_taken:  cover property (vec_req_i ##1 vec_valid_o);
    c_host_deny:  cover property (hp_rd_i && sec_rr && !hp_in_win);
    c_rom_locked: cover property (lock_d ##1 rom_lock_o);
    c_conflict:   cover property (conflict_d);
    c_rom_fetch:  cover property (pf_d.rom ##1 exec_rom_q);
endmodule

/* shared/oms_cfg.svh */
// Constants for the on-chip memory map and security block
// Behaviour
// [R1] Eight dual blocks: two reads or read+write
// [R2] Dual 0-3 in data; program when overlaid
// [R3] Dual 4-7 in program; data when mapped
// [R4] Eight single blocks, one access each per cycle
// [R5] Single blocks only in program space
// [R6] Data dual blocks on consecutive 8K ranges
// [R7] Program dual 4-7 at 018000h-01FFFFh
// [R8] Single 0-3 at 028000h, 4-7 at 038000h
// [R9] Non-ROM code reading ROM gets 0FFFFh
// [R10] RAM reads never restricted by security
// [R11] Security disables scan emulation, not boundary scan
// [R12] RAM/ROM option forces ROM enabled at reset
// [R13] RAM/ROM option: host reads only 4000h-5FFFh
// [R14] ROM-only: mode from pin, host unrestricted
// [R15] Vector taken loads PC, four-word slots
// [R16] Vectors at FF80h, then pointer-selected page
// [R17] Hardware reset sets pointer to all ones
// [R18] Pointer bits 15-7, reset 1FFh, kept
// [R19] Mode bit 6: 0 ROM present, 1 absent
// [R20] Mode bit captures pin at reset, writable
// [R21] Overlay bit 5, page 0 never in program
// [R22] Data-map bit 3 gates dual 4-7
// [R23] Vector address is pointer plus slot offset
`ifndef OMS_CFG_SVH
`define OMS_CFG_SVH
`define OMS_REG_AW        4
`define OMS_OFS_MODE      4'h0
`define OMS_OFS_STAT      4'h1
`define OMS_VPP_HI        15
`define OMS_VPP_LO        7
`define OMS_BIT_ROMDIS    6
`define OMS_BIT_OVERLAY_BIT      5
`define OMS_BIT_DMAP      3
`define OMS_VPP_RST       9'h1ff
`define OMS_OVERLAY_BIT_RST      1'b0
`define OMS_DMAP_RST      1'b0
`define OMS_ROM_LOCK_VAL  16'hffff
`define OMS_HP_LO         16'h4000
`define OMS_HP_HI         16'h5fff
`define OMS_PG_LOW        7'h00
`define OMS_PG_DUAL       7'h01
`define OMS_PG_SGL_A      7'h02
`define OMS_PG_SGL_B      7'h03
`define OMS_NBLK          8
`endif

/* shared/oms_pkg.sv */
// Types for the on-chip memory map and security block
package oms_pkg;
    typedef enum logic [1:0] {
        OMS_SEC_NONE    = 2'b00,
        OMS_SEC_ROM     = 2'b01,
        OMS_SEC_RAM_ROM = 2'b10,
        OMS_SEC_RSVD    = 2'b11
    } oms_sec_e;
    typedef struct packed {
        logic        vld;
        logic [22:0] addr;
    } oms_acc_s;
    typedef struct packed {
        logic       dual;
        logic       single;
        logic       rom;
        logic [2:0] idx;
    } oms_sel_s;
endpackage
